// ### core/timer_b_pwm_control.sv
// Timer with two capture/compare/PWM channels and a classic Wishbone slave
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "timer_b_consts.svh"
module timer_b_pwm_control
  import timer_b_pkg::*;
#(
  parameter int CNT_W = `TMB_CNT_W
) (
  input  wire logic                  clk_i,        // 10 MHz bus clock
  input  wire logic                  rst_i,        // Synchronous reset, high
  input  wire logic                  cyc_i,        // Wishbone cycle
  input  wire logic                  stb_i,        // Wishbone strobe
  input  wire logic                  we_i,         // Wishbone write
  input  wire logic [`TMB_ADR_W-1:0] adr_i,        // Byte address
  input  wire logic [3:0]            sel_i,        // Byte enables
  input  wire logic [31:0]           dat_i,        // Write data
  output logic      [31:0]           dat_o,        // Read data
  output logic                       ack_o,        // Wishbone acknowledge
  input  wire logic                  wait_mode_i,  // Processor in wait mode
  input  wire logic                  stop_mode_i,  // Processor in stop mode
  input  wire logic                  break_i,      // Debug break active
  input  wire logic                  break_clear_enable_i, // Flags clearable in break
  input  wire logic                  ext_clk_i,    // External count clock pin
  output logic                       ext_clk_force_input_o, // Pin forced to input
  input  wire logic [1:0]            ch_pin_i,     // Channel pin levels
  output logic      [1:0]            ch_pin_o,     // Channel pin drive level
  output logic      [1:0]            ch_pin_oe_o,  // Channel pin drive enable
  output logic                       ovf_irq_o,    // Overflow request
  output logic      [1:0]            ch_irq_o,     // Channel requests
  output logic                       wake_o        // Wait-mode wakeup request
);

  function automatic chan_mode_e chan_mode(input logic [6:0] ctl);
    chan_mode_e m;
    m = MODE_PORT;
    if (ctl[`TMB_BUF_BIT] && ctl[`TMB_ELSB_BIT:`TMB_ELSA_BIT] != `TMB_ELS_PORT) begin
      m = MODE_BUFFERED;
    end else if (ctl[`TMB_ELSB_BIT:`TMB_ELSA_BIT] == `TMB_ELS_PORT) begin
      m = MODE_PORT;
    end else if (ctl[`TMB_MSA_BIT]) begin
      m = MODE_COMPARE;
    end else begin
      m = MODE_CAPTURE;
    end
    return m;
  endfunction

  function automatic logic [5:0] presc_mask(input logic [2:0] ps);
    logic [5:0] m;
    m = 6'h00;
    case (ps)
      3'h1:    m = 6'h01;
      3'h2:    m = 6'h03;
      3'h3:    m = 6'h07;
      3'h4:    m = 6'h0F;
      3'h5:    m = 6'h1F;
      3'h6:    m = 6'h3F;
      default: m = 6'h00;
    endcase
    return m;
  endfunction

  logic             ovf_ie_reg;
  logic             halt_reg;
  logic [2:0]       presc_sel_reg;
  logic [5:0]       presc_cnt_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] mod_reg;
  logic [6:0]       ctl_reg   [2];
  logic [CNT_W-1:0] cmp_reg   [2];
  logic [2:0]       flag_reg;
  logic [2:0]       armed_reg;
  logic [1:0]       out_reg;
  logic [1:0]       pin_prev_reg;
  logic             ext_prev_reg;
  logic             last_reg;
  logic             act_reg;

  logic             req;
  logic             wr;
  logic             rd;
  logic             wr_lo;
  logic             wr_hi;
  logic             trst_wr;
  logic             run;
  logic             ext_sel;
  logic             tick;
  logic             ovf_ev;
  logic             buffered;
  logic             clear_ok;
  logic [2:0]       ev;
  logic [2:0]       rd_hit;
  logic [2:0]       wr_zero;
  logic [1:0]       cap_ev;
  logic [1:0]       cmp_ev;
  logic [1:0]       drive;
  logic [31:0]      rd_data;
  logic [CNT_W-1:0] cmp_val   [2];
  chan_mode_e       mode      [2];

  // Bus access; registers stay unreachable in wait mode
  // [RQ18] wait blocks bus
  assign req     = cyc_i & stb_i & ~ack_o;
  assign wr      = req & we_i & ~wait_mode_i;
  assign rd      = req & ~we_i & ~wait_mode_i;
  assign wr_lo   = wr & sel_i[0];
  assign wr_hi   = wr & sel_i[1];
  // [RQ17] counter reset strobe
  assign trst_wr = wr_lo & (adr_i == `TMB_OFS_SC) & dat_i[`TMB_TRST_BIT];

  // [RQ1] buffered link select
  assign buffered = (mode[0] == MODE_BUFFERED);
  // [RQ21] break clear gate
  assign clear_ok = ~break_i | break_clear_enable_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (adr_i)
      `TMB_OFS_SC:   rd_data[7:0] = {flag_reg[0], ovf_ie_reg, halt_reg, 2'b00, presc_sel_reg};
      `TMB_OFS_CNT:  rd_data[CNT_W-1:0] = cnt_reg;
      `TMB_OFS_MOD:  rd_data[CNT_W-1:0] = mod_reg;
      `TMB_OFS_CTL0: rd_data[7:0] = {flag_reg[1], ctl_reg[0]};
      `TMB_OFS_CMP0: rd_data[CNT_W-1:0] = cmp_reg[0];
      `TMB_OFS_CTL1: rd_data[7:0] = {flag_reg[2], ctl_reg[1]};
      `TMB_OFS_CMP1: rd_data[CNT_W-1:0] = cmp_reg[1];
      default:       rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req) begin
      dat_o <= rd ? rd_data : 32'h0000_0000;
    end
  end

  // Status and control fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_ie_reg    <= 1'b0;
      // [RQ15] halted after reset
      halt_reg      <= 1'b1;
      presc_sel_reg <= 3'h0;
    end else if (wr_lo && adr_i == `TMB_OFS_SC) begin
      ovf_ie_reg    <= dat_i[`TMB_IE_BIT];
      halt_reg      <= dat_i[`TMB_HALT_BIT];
      presc_sel_reg <= dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_reg <= `TMB_MOD_RST;
    end else if (adr_i == `TMB_OFS_MOD) begin
      if (wr_lo) begin
        mod_reg[7:0] <= dat_i[7:0];
      end
      if (wr_hi) begin
        mod_reg[CNT_W-1:8] <= dat_i[CNT_W-1:8];
      end
    end
  end

  // Counter clock selection
  // [RQ15] [RQ19] [RQ20] halt, stop, break freeze
  assign run     = ~halt_reg & ~stop_mode_i & ~break_i;
  // [RQ22] external clock select
  assign ext_sel = (presc_sel_reg == `TMB_PS_EXT);
  // [RQ24] prescaler division taps
  assign tick    = run & (ext_sel ? (ext_clk_i & ~ext_prev_reg)
                                  : ((presc_cnt_reg & presc_mask(presc_sel_reg))
                                     == presc_mask(presc_sel_reg)));
  // [RQ11] overflow on wrap
  assign ovf_ev  = tick & (cnt_reg == mod_reg) & ~trst_wr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_prev_reg <= 1'b0;
    end else if (!stop_mode_i) begin
      ext_prev_reg <= ext_clk_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || trst_wr) begin
      presc_cnt_reg <= 6'h00;
    end else if (run && !ext_sel) begin
      presc_cnt_reg <= presc_cnt_reg + 6'h01;
    end
  end

  // [RQ26] up-counter with wrap
  always_ff @(posedge clk_i) begin
    if (rst_i || trst_wr) begin
      // [RQ17] counter cleared
      cnt_reg <= '0;
    end else if (tick) begin
      // [RQ25] restart from zero
      cnt_reg <= (cnt_reg == mod_reg) ? '0 : cnt_reg + 1'b1;
    end
  end

  // Buffered pair selection
  always_ff @(posedge clk_i) begin
    if (rst_i || !buffered) begin
      last_reg <= 1'b0;
      act_reg  <= 1'b0;
    end else begin
      // [RQ2] [RQ3] track last written
      if (wr && adr_i == `TMB_OFS_CMP0) begin
        last_reg <= 1'b0;
      end else if (wr && adr_i == `TMB_OFS_CMP1) begin
        last_reg <= 1'b1;
      end
      // [RQ3] swap at overflow
      if (ovf_ev) begin
        act_reg <= (wr && adr_i == `TMB_OFS_CMP1) ? 1'b1
                 : (wr && adr_i == `TMB_OFS_CMP0) ? 1'b0 : last_reg;
      end
    end
  end

  assign ev = {cap_ev[1] | cmp_ev[1], cap_ev[0] | cmp_ev[0], ovf_ev};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_chan
      localparam logic [`TMB_ADR_W-1:0] CTL_OFS = (g == 0) ? `TMB_OFS_CTL0 : `TMB_OFS_CTL1;
      localparam logic [`TMB_ADR_W-1:0] CMP_OFS = (g == 0) ? `TMB_OFS_CMP0 : `TMB_OFS_CMP1;
      logic [1:0] els;
      logic       rise;
      logic       fall;

      // [RQ4] channel 1 control ignored when linked
      // [RQ7] mode pair decode
      assign mode[g] = (g == 1 && buffered) ? MODE_PORT : chan_mode(ctl_reg[g]);
      assign els     = ctl_reg[g][`TMB_ELSB_BIT:`TMB_ELSA_BIT];
      assign rise    = ch_pin_i[g] & ~pin_prev_reg[g];
      assign fall    = ~ch_pin_i[g] & pin_prev_reg[g];
      // [RQ2] active set of the pair
      assign cmp_val[g] = (g == 0 && buffered) ? cmp_reg[act_reg] : cmp_reg[g];
      // [RQ16] [RQ20] captures only while running
      assign cap_ev[g]  = run & (mode[g] == MODE_CAPTURE)
                        & ((els[0] & rise) | (els[1] & fall));
      // [RQ14] compare event
      assign cmp_ev[g]  = tick & ~trst_wr & (cnt_reg == cmp_val[g])
                        & (mode[g] == MODE_COMPARE || mode[g] == MODE_BUFFERED);
      assign drive[g]   = (mode[g] == MODE_COMPARE || mode[g] == MODE_BUFFERED);

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ctl_reg[g] <= 7'h00;
        end else if (wr_lo && adr_i == CTL_OFS) begin
          ctl_reg[g] <= (g == 0) ? dat_i[6:0]
                                 : (dat_i[6:0] & ~(7'h01 << `TMB_BUF_BIT));
        end
      end

      // Capture wins over a bus write in the same cycle
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cmp_reg[g] <= '0;
        end else if (cap_ev[g]) begin
          cmp_reg[g] <= cnt_reg;
        end else if (adr_i == CMP_OFS) begin
          if (wr_lo) begin
            cmp_reg[g][7:0] <= dat_i[7:0];
          end
          if (wr_hi) begin
            cmp_reg[g][CNT_W-1:8] <= dat_i[CNT_W-1:8];
          end
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_prev_reg[g] <= 1'b0;
        end else begin
          pin_prev_reg[g] <= ch_pin_i[g];
        end
      end

      // Channel output level
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          out_reg[g] <= 1'b1;
        end else if (!drive[g]) begin
          out_reg[g] <= ~ctl_reg[g][`TMB_MSA_BIT];
        end else if (ctl_reg[g][`TMB_MAX_BIT] && !ctl_reg[g][`TMB_TOV_BIT]) begin
          // [RQ10] full duty
          out_reg[g] <= 1'b1;
        end else if (cmp_ev[g]) begin
          // [RQ8] compare action
          case (els)
            `TMB_ELS_CLEAR:  out_reg[g] <= 1'b0;
            `TMB_ELS_SET:    out_reg[g] <= 1'b1;
            `TMB_ELS_TOGGLE: out_reg[g] <= ~out_reg[g];
            default:         out_reg[g] <= out_reg[g];
          endcase
        end else if (ovf_ev && ctl_reg[g][`TMB_TOV_BIT]) begin
          // [RQ9] toggle on overflow
          out_reg[g] <= ~out_reg[g];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ch_pin_o[g]    <= 1'b0;
          ch_pin_oe_o[g] <= 1'b0;
          ch_irq_o[g]    <= 1'b0;
        end else begin
          ch_pin_o[g]    <= out_reg[g];
          // [RQ4] channel 1 pin freed
          ch_pin_oe_o[g] <= drive[g];
          // [RQ14] channel request gate
          ch_irq_o[g]    <= flag_reg[g+1] & ctl_reg[g][`TMB_IE_BIT];
        end
      end
    end

    // Sticky flags with read-then-write-zero clearing
    for (g = 0; g < 3; g++) begin : gen_flag
      localparam logic [`TMB_ADR_W-1:0] OWN_OFS = (g == 0) ? `TMB_OFS_SC
                                                 : (g == 1) ? `TMB_OFS_CTL0 : `TMB_OFS_CTL1;
      assign rd_hit[g]  = rd & (adr_i == OWN_OFS);
      assign wr_zero[g] = wr_lo & (adr_i == OWN_OFS) & ~dat_i[`TMB_FLAG_BIT];

      // [RQ12] two-step clear, event wins
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flag_reg[g]  <= 1'b0;
          armed_reg[g] <= 1'b0;
        end else if (ev[g]) begin
          flag_reg[g]  <= 1'b1;
          armed_reg[g] <= 1'b0;
        end else if (wr_zero[g] && armed_reg[g] && clear_ok) begin
          // [RQ21] clear held during break
          flag_reg[g]  <= 1'b0;
          armed_reg[g] <= 1'b0;
        end else if (rd_hit[g] && flag_reg[g] && clear_ok) begin
          armed_reg[g] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_irq_o             <= 1'b0;
      wake_o                <= 1'b0;
      ext_clk_force_input_o <= 1'b0;
    end else begin
      // [RQ13] overflow request gate
      ovf_irq_o             <= ovf_ie_reg & flag_reg[0];
      // [RQ18] enabled request wakes
      wake_o                <= (ovf_ie_reg & flag_reg[0])
                             | (ctl_reg[0][`TMB_IE_BIT] & flag_reg[1])
                             | (ctl_reg[1][`TMB_IE_BIT] & flag_reg[2]);
      // [RQ23] pin forced to input
      ext_clk_force_input_o <= ext_sel;
    end
  end

endmodule
`default_nettype wire

// ### inc/timer_b_consts.svh
// Register map, field positions, reset values and codes of the PWM timer block
// Function
// [RQ1] Buffered bit links channels, overrides unbuffered bit
// [RQ2] Channel 1 takes over next period
// [RQ3] Last written set rules after each overflow
// [RQ4] Channel 0 control rules; channel 1 freed
// [RQ5] Software writes only the inactive set
// [RQ6] Software: halt, reset, program, then release
// [RQ7] Mode pair 0:1 unbuffered, 1:0 buffered
// [RQ8] Edge pair 1:0 clears, 1:1 sets
// [RQ9] Overflow toggle bit; clear gives 0% duty
// [RQ10] Full duty bit without toggle: 100%
// [RQ11] Overflow flag set on wrap to zero
// [RQ12] Flag clears by read then write 0
// [RQ13] Overflow request needs enable and flag
// [RQ14] Channel flag on capture/compare; enable gates request
// [RQ15] Halt bit freezes counter; set at reset
// [RQ16] Halt bit inhibits input captures
// [RQ17] Counter reset bit zeroes counter, prescaler
// [RQ18] Wait mode: runs, bus blocked, wakes
// [RQ19] Stop mode freezes everything, keeps state; here bus access and flag logic keep running
// [RQ20] Break halts counter, blocks captures
// [RQ21] Break clears only with clear enable
// [RQ22] Prescale code all ones: external clock
// [RQ23] External clock pin forced to input
// [RQ24] Codes 000-110 divide by 1 to 64
// [RQ25] Counter equals modulo: restart at zero
// [RQ26] 16-bit up-counter on selected clock edge
`ifndef TIMER_B_CONSTS_SVH
`define TIMER_B_CONSTS_SVH
`define TMB_CNT_W       16
`define TMB_ADR_W       5
`define TMB_OFS_SC      5'h00
`define TMB_OFS_CNT     5'h04
`define TMB_OFS_MOD     5'h08
`define TMB_OFS_CTL0    5'h0C
`define TMB_OFS_CMP0    5'h10
`define TMB_OFS_CTL1    5'h14
`define TMB_OFS_CMP1    5'h18
`define TMB_FLAG_BIT    7
`define TMB_IE_BIT      6
`define TMB_HALT_BIT    5
`define TMB_BUF_BIT     5
`define TMB_TRST_BIT    4
`define TMB_MSA_BIT     4
`define TMB_ELSB_BIT    3
`define TMB_ELSA_BIT    2
`define TMB_TOV_BIT     1
`define TMB_MAX_BIT     0
`define TMB_PS_EXT      3'h7
`define TMB_MOD_RST     16'hFFFF
`define TMB_ELS_TOGGLE  2'h1
`define TMB_ELS_CLEAR   2'h2
`define TMB_ELS_SET     2'h3
`define TMB_ELS_PORT    2'h0
`endif

// ### inc/timer_b_pkg.sv
// Types shared by the PWM timer block
package timer_b_pkg;
  typedef enum logic [3:0] {
    MODE_PORT     = 4'b0001,
    MODE_CAPTURE  = 4'b0010,
    MODE_COMPARE  = 4'b0100,
    MODE_BUFFERED = 4'b1000
  } chan_mode_e;
endpackage

// ### verif/timer_b_pwm_control_properties.sv
// Port checker for the PWM timer block
`timescale 1ns/1ps
`default_nettype none
`include "timer_b_consts.svh"
module timer_b_pwm_control_properties (
  input wire logic        clk_i,                 // Clock
  input wire logic        rst_i,                 // Reset
  input wire logic        cyc_i,                 // Cycle
  input wire logic        stb_i,                 // Strobe
  input wire logic        we_i,                  // Write
  input wire logic [4:0]  adr_i,                 // Address
  input wire logic [3:0]  sel_i,                 // Lanes
  input wire logic [31:0] dat_i,                 // Write data
  input wire logic [31:0] dat_o,                 // Read data
  input wire logic        ack_o,                 // Ack
  input wire logic        wait_mode_i,           // Wait mode
  input wire logic        ext_clk_force_input_o, // Pin input
  input wire logic [1:0]  ch_pin_o,              // Pin level
  input wire logic [1:0]  ch_pin_oe_o,           // Pin enable
  input wire logic        ovf_irq_o,             // Overflow request
  input wire logic [1:0]  ch_irq_o,              // Channel requests
  input wire logic        wake_o                 // Wakeup
);
  logic [7:0] ctl0_reg;
  logic       wr;
  logic       f_full;
  logic       f_buf;
  assign wr = cyc_i && stb_i && !ack_o && we_i && !wait_mode_i && sel_i[0];
  assign f_full = ctl0_reg[0] && !ctl0_reg[1] && ctl0_reg[3:2] != 2'h0 && |ctl0_reg[5:4];
  assign f_buf = ctl0_reg[5] && ctl0_reg[3:2] != 2'h0;
  // Shadow of channel 0 control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl0_reg <= 8'h00;
    end else if (wr && adr_i == `TMB_OFS_CTL0) begin
      ctl0_reg <= dat_i[7:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("request not answered by one ack pulse");
  ack_idle_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  wait_read_a: assert property (wait_mode_i && cyc_i && stb_i && !ack_o && !we_i |=> dat_o == 32'h0)
    else $error("register readable in wait mode");
  wake_req_a: assert property (ovf_irq_o || ch_irq_o != 2'h0 |-> ##[0:1] wake_o)
    else $error("request without wakeup");
  ext_sel_a: assert property (wr && adr_i == `TMB_OFS_SC && dat_i[2:0] == 3'h7 |-> ##[1:2] ext_clk_force_input_o)
    else $error("clock pin not forced to input");
  ext_off_a: assert property (wr && adr_i == `TMB_OFS_SC && dat_i[2:0] != 3'h7 |-> ##[1:2] !ext_clk_force_input_o)
    else $error("clock pin held as input");
  reset_quiet_a: assert property ($fell(rst_i) |-> !ovf_irq_o && ch_irq_o == 2'h0 && ch_pin_oe_o == 2'h0)
    else $error("outputs active after reset");
  ovf_mask_a: assert property (wr && adr_i == `TMB_OFS_SC && !dat_i[6] |-> ##[1:2] !ovf_irq_o)
    else $error("overflow request while disabled");
  ch_mask_a: assert property (wr && adr_i == `TMB_OFS_CTL0 && !dat_i[6] |-> ##[1:2] !ch_irq_o[0])
    else $error("channel request while disabled");
  buf_free_a: assert property (f_buf && $past(f_buf) && $past(f_buf, 2) && $past(f_buf, 3) |-> !ch_pin_oe_o[1])
    else $error("channel 1 pin driven while linked");
  full_duty_a: assert property (f_full && $past(f_full) && $past(f_full, 2) && $past(f_full, 3) |-> ch_pin_o[0])
    else $error("full duty output low");
endmodule
bind timer_b_pwm_control timer_b_pwm_control_properties timer_b_pwm_control_properties_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .wait_mode_i(wait_mode_i),
  .ext_clk_force_input_o(ext_clk_force_input_o), .ch_pin_o(ch_pin_o), .ch_pin_oe_o(ch_pin_oe_o),
  .ovf_irq_o(ovf_irq_o), .ch_irq_o(ch_irq_o), .wake_o(wake_o)
);
`default_nettype wire

// ### verif/pin_partner.sv
// Pulse sources standing at the timer's clock and channel pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic       clk_i,     // Bench clock
  input  wire logic       run_i,     // Sources active
  output logic            ext_clk_o, // External count clock
  output logic      [1:0] src_o      // Capture sources
);
  logic [3:0] div_reg = 4'h0;
  // Sources stand still while not running
  always_ff @(posedge clk_i) begin
    if (run_i) begin
      div_reg <= div_reg + 4'h1;
    end
  end
  assign ext_clk_o = div_reg[2];
  assign src_o = {div_reg[3], ~div_reg[3]};
endmodule
`default_nettype wire

// ### verif/timer_b_pwm_control_tb.sv
// Self-checking bench for the PWM timer block
`timescale 1ns/1ps
`default_nettype none
`include "timer_b_consts.svh"
module timer_b_pwm_control_tb;
  localparam logic [4:0] SC = `TMB_OFS_SC, CNT = `TMB_OFS_CNT, MD = `TMB_OFS_MOD;
  localparam logic [4:0] C0 = `TMB_OFS_CTL0, P0 = `TMB_OFS_CMP0;
  localparam logic [4:0] C1 = `TMB_OFS_CTL1, P1 = `TMB_OFS_CMP1;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [4:0]  adr_i = 5'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        wait_mode_i = 1'b0, stop_mode_i = 1'b0, break_i = 1'b0, run = 1'b0;
  logic        ack_o, ovf_irq_o, wake_o, force_o, ext_clk_i;
  logic        break_clear_enable_i = 1'b0;
  logic [1:0]  ch_pin_i, ch_pin_o, ch_pin_oe_o, ch_irq_o, src;
  int          n_errors = 0, checked = 0, cycles = 0, n;
  logic [4:0]  t_adr [5] = '{P0, P1, P0, C0, C0};
  logic [31:0] t_val [5] = '{32'h4, 32'hA, 32'h2, 32'h78, 32'h79};
  int          t_hi [5] = '{20, 44, 12, 0, 64};
  timer_b_pwm_control timer_b_pwm_control_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i), .break_i(break_i),
    .break_clear_enable_i(break_clear_enable_i),
    .ext_clk_i(ext_clk_i), .ext_clk_force_input_o(force_o),
    .ch_pin_i(ch_pin_i), .ch_pin_o(ch_pin_o), .ch_pin_oe_o(ch_pin_oe_o),
    .ovf_irq_o(ovf_irq_o), .ch_irq_o(ch_irq_o), .wake_o(wake_o)
  );
  pin_partner pin_partner_i (.clk_i(clk_i), .run_i(run), .ext_clk_o(ext_clk_i), .src_o(src));
  // Pin level from both drivers
  assign ch_pin_i = (ch_pin_oe_o & ch_pin_o) | (~ch_pin_oe_o & src);
  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'h3;
    @(posedge clk_i iff ack_o === 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic rng(input logic [31:0] got, input int e, input int tol);
    chk({31'h0, (got + tol >= e) && (got <= e + tol)}, 32'h1);
  endtask
  task automatic duty(input int c, output int k);
    k = 0;
    repeat (64) begin
      @(posedge clk_i);
      k += (ch_pin_o[c] === 1'b1);
    end
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(SC, 32'h20);
    rdc(MD, 32'hFFFF);
    rdc(5'h1C, 32'h0);
    repeat (10) @(posedge clk_i);
    rdc(CNT, 32'h0);
    wb(1'b1, SC, 32'h30);
    wb(1'b1, MD, 32'hFF);
    wb(1'b1, SC, 32'h40);
    @(posedge clk_i iff ovf_irq_o === 1'b1);
    rdc(SC, 32'hC0);
    wb(1'b1, SC, 32'h40);
    rdc(SC, 32'h40);
    chk({31'h0, ovf_irq_o}, 32'h0);
    wb(1'b1, SC, 32'hC0);
    rdc(SC, 32'h40);
    @(posedge clk_i iff ovf_irq_o === 1'b1);
    wb(1'b1, SC, 32'h40);
    rdc(SC, 32'hC0);
    wb(1'b1, SC, 32'h20);
    wb(1'b1, SC, 32'h30);
    rdc(CNT, 32'h0);
    rdc(SC, 32'h20);
    rdc(MD, 32'hFF);
    wb(1'b1, MD, 32'hFFFF);
    for (int ps = 0; ps < 8; ps++) begin
      wb(1'b1, SC, 32'h30);
      run <= (ps == 7);
      wb(1'b1, SC, 32'(ps));
      repeat (256) @(posedge clk_i);
      chk({31'h0, force_o}, 32'(ps == 7));
      wb(1'b1, SC, 32'h20 | 32'(ps));
      wb(1'b0, CNT, 32'h0);
      n = (ps == 7) ? 32 : (256 >> ps);
      rng(rd, n + 2, 3);
    end
    run <= 1'b0;
    wb(1'b1, SC, 32'h00);
    for (int k = 0; k < 2; k++) begin
      {stop_mode_i, break_i} <= 2'b10 >> k;
      wb(1'b0, CNT, 32'h0);
      n = rd;
      repeat (20) @(posedge clk_i);
      rdc(CNT, 32'(n));
      {stop_mode_i, break_i} <= 2'b00;
      @(posedge clk_i);
    end
    wait_mode_i <= 1'b1;
    rdc(MD, 32'h0);
    wb(1'b1, SC, 32'h20);
    wait_mode_i <= 1'b0;
    wb(1'b0, CNT, 32'h0);
    n = rd;
    wb(1'b0, CNT, 32'h0);
    chk(rd - 32'(n), 32'h3);
    wb(1'b1, SC, 32'h30);
    wb(1'b1, MD, 32'hF);
    wb(1'b1, C0, 32'h7A);
    wb(1'b1, C1, 32'h1B);
    wb(1'b1, SC, 32'h00);
    for (int j = 0; j < 5; j++) begin
      wb(1'b1, t_adr[j], t_val[j]);
      repeat (48) @(posedge clk_i);
      duty(0, n);
      rng(32'(n), t_hi[j], 1);
    end
    chk({30'h0, ch_pin_oe_o}, 32'h1);
    rdc(C0, 32'hF9);
    chk({31'h0, ch_irq_o[0]}, 32'h1);
    wb(1'b1, SC, 32'h20);
    wb(1'b1, C1, 32'h04);
    wb(1'b1, C0, 32'h00);
    run <= 1'b1;
    repeat (40) @(posedge clk_i);
    rdc(C1, 32'h04);
    wb(1'b1, SC, 32'h00);
    repeat (40) @(posedge clk_i);
    wb(1'b1, SC, 32'h20);
    rdc(C1, 32'h84);
    break_i <= 1'b1;
    wb(1'b1, C1, 32'h04);
    rdc(C1, 32'h84);
    chk({30'h0, ch_irq_o}, 32'h0);
    break_i <= 1'b0;
    wb(1'b1, C1, 32'h04);
    rdc(C1, 32'h04);
    wb(1'b1, SC, 32'h30);
    wb(1'b1, P1, 32'h6);
    wb(1'b1, C1, 32'h1A);
    wb(1'b1, SC, 32'h00);
    repeat (48) @(posedge clk_i);
    duty(1, n);
    rng(32'(n), 28, 1);
    {break_i, break_clear_enable_i} <= 2'b11;
    rdc(C1, 32'h9A);
    wb(1'b1, C1, 32'h1A);
    rdc(C1, 32'h1A);
    {break_i, break_clear_enable_i} <= 2'b00;
    print_verdict();
  end
endmodule
`default_nettype wire
